// *** hdl/mpf_regs.svh ***
`ifndef MPF_REGS_SVH
`define MPF_REGS_SVH
// register byte offsets on the ahb-lite port
`define MPF_OFS_FRAME_ON   5'h00
`define MPF_OFS_CHECKS     5'h04
`define MPF_OFS_PRIO_GATE  5'h08
`define MPF_OFS_STATUS     5'h0c
`define MPF_OFS_IRQ_STAT   5'h10
`define MPF_OFS_IRQ_MASK   5'h14
// field positions
`define MPF_POS_TX_GATE    16
`define MPF_POS_VALID      16
`define MPF_CHK_WIDTH      5
// check bit order inside each five-bit group
`define MPF_CHK_MCAST      0
`define MPF_CHK_UCAST      1
`define MPF_CHK_SA         2
`define MPF_CHK_ETYPE      3
`define MPF_CHK_OPCODE     4
// interrupt status bits
`define MPF_IRQ_PAUSE_RX   0
`define MPF_IRQ_REJECT     1
`define MPF_IRQ_CTRL_RX    2
`define MPF_IRQ_TX_PAUSE   3
// reset values
`define MPF_RST_FRAME_ON   4'hf
`define MPF_RST_CHECKS     20'hfffff
`define MPF_RST_GATE       9'h1ff
`define MPF_RST_MASK       4'h0
`endif

// *** hdl/mpf_pkg.sv ***
package mpf_pkg;
  // received frame class, also the index of its enable bit and check group
  typedef enum logic [1:0] {
    MPF_GCP = 2'b00,
    MPF_PCP = 2'b01,
    MPF_GPP = 2'b10,
    MPF_PPP = 2'b11
  } mpf_class_t;

  // one parsed control frame from the receive datapath
  typedef struct packed {
    logic             strobe;
    mpf_class_t       kind;
    logic [4:0]       match;
    logic [7:0]       prio_vec;
    logic [7:0][15:0] quanta;
  } mpf_rx_frame_t;

  // one transmitted pause frame from the transmit datapath
  typedef struct packed {
    logic strobe;
    logic global_pause;
    logic fcs_good;
  } mpf_tx_done_t;

  // complete state of the block
  typedef struct packed {
    logic [3:0]       frame_on;
    logic [19:0]      checks;
    logic [8:0]       rx_gate;
    logic [8:0]       tx_gate;
    logic [8:0]       req;
    logic [8:0]       valid;
    logic [8:0][15:0] quanta;
    logic [3:0]       irq_stat;
    logic [3:0]       irq_mask;
    logic             stat_pause;
    logic             stat_user_pause;
    logic             dp_pend;
    logic             dp_write;
    logic [4:0]       dp_addr;
    logic [31:0]      rdata;
  } mpf_state_t;
endpackage

// *** hdl/mpf_pause_ctrl.sv ***
// Functional notes
// - per-priority receive gate masks quanta delivery to user, not internal frame handling
// - transmit pause frames go out only for priorities whose transmit gate is set
// - global control frames are handled only while their enable bit is set
// - global control frames: each of five address/type/opcode checks applies when enabled
// - priority control frames are handled only while their enable bit is set
// - priority control frames: each of five checks applies only when its bit is set
// - global pause frames are handled only while their enable bit is set
// - global pause frames: each of five checks applies only when its bit is set
// - priority pause frames are handled only while their enable bit is set
// - priority pause frames: each of five checks applies only when its bit is set
// - accepted pause frame sets its request bit, held until the frame is processed
// - valid bit marks fresh quanta that user logic must then act on
// - a standard global pause frame reports on valid bit 8
// - sixteen-bit quanta per priority 0..7, global pause quanta in slot 8
// - one-cycle transmit statistics pulses for good global and priority pause frames
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`include "mpf_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module mpf_pause_ctrl
  import mpf_pkg::*;
#(
  parameter int PRIOS = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_hsel,
  input  wire logic [31:0]      i_haddr,
  input  wire logic [1:0]       i_htrans,
  input  wire logic             i_hwrite,
  input  wire logic [2:0]       i_hsize,
  input  wire logic [31:0]      i_hwdata,
  input  wire logic             i_hready,
  output logic                  o_hreadyout,
  output logic                  o_hresp,
  output logic [31:0]           o_hrdata,
  input  wire mpf_rx_frame_t    i_rx_frame,
  input  wire logic [8:0]       i_rx_flow_frame_acknowledge,
  output logic [8:0]            o_rx_flow_request,
  output logic [8:0]            o_rx_flow_valid,
  output logic [8:0][15:0]      o_rx_flow_quanta,
  input  wire logic [8:0]       i_tx_flow_frame_request,
  output logic [8:0]            o_tx_flow_frame_send,
  input  wire mpf_tx_done_t     i_tx_done,
  output logic                  o_tx_stat_pause,
  output logic                  o_tx_stat_user_pause,
  output logic                  o_irq
);

  mpf_state_t st_ff;
  mpf_state_t nxt_st;

  logic [4:0]       chk_en;
  logic             class_on;
  logic             frame_ok;
  logic [8:0]       slot_hit;
  logic [8:0][15:0] slot_q;
  logic             addr_phase;

  ////////////////////////////////////////////////////////////////////////////
  // receive frame qualification
  // a disabled check is treated as passed, so a zero check word accepts any frame whose class enable bit is set
  always_comb
  begin
    chk_en   = st_ff.checks[`MPF_CHK_WIDTH*i_rx_frame.kind +: `MPF_CHK_WIDTH];
    class_on = st_ff.frame_on[i_rx_frame.kind];
    frame_ok = i_rx_frame.strobe & class_on & (&(~chk_en | i_rx_frame.match));
  end

  // per-slot delivery: priorities 0..7 from priority pause, slot 8 from global pause
  genvar g;
  generate
    for (g = 0; g <= PRIOS; g = g + 1)
    begin : g_slot
      if (g < PRIOS)
      begin : g_prio
        assign slot_hit[g] = frame_ok & (i_rx_frame.kind == MPF_PPP) & i_rx_frame.prio_vec[g]
                             & st_ff.rx_gate[g];
        assign slot_q[g]   = i_rx_frame.quanta[g];
      end
      else
      begin : g_global
        assign slot_hit[g] = frame_ok & (i_rx_frame.kind == MPF_GPP) & st_ff.rx_gate[g];
        assign slot_q[g]   = i_rx_frame.quanta[0];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // register read mux, fed with the next state so a read right after a write sees it
  function automatic logic [31:0] read_word(input mpf_state_t s, input logic [4:0] a);
    logic [31:0] w;
    w = '0;
    case (a)
      `MPF_OFS_FRAME_ON:  w[3:0] = s.frame_on;
      `MPF_OFS_CHECKS:    w[19:0] = s.checks;
      `MPF_OFS_PRIO_GATE:
      begin
        w[8:0] = s.rx_gate;
        w[`MPF_POS_TX_GATE +: 9] = s.tx_gate;
      end
      `MPF_OFS_STATUS:
      begin
        w[8:0] = s.req;
        w[`MPF_POS_VALID +: 9] = s.valid;
      end
      `MPF_OFS_IRQ_STAT:  w[3:0] = s.irq_stat;
      `MPF_OFS_IRQ_MASK:  w[3:0] = s.irq_mask;
      default:            w = '0;
    endcase
    return w;
  endfunction

  assign addr_phase = i_hsel & i_htrans[1] & i_hready;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic for the whole block
  always_comb
  begin
    nxt_st                 = st_ff;
    nxt_st.valid           = '0;
    nxt_st.stat_pause      = 1'b0;
    nxt_st.stat_user_pause = 1'b0;

    // ahb data phase write; unmapped offsets are silently dropped
    if (st_ff.dp_pend && st_ff.dp_write)
    begin
      case (st_ff.dp_addr)
        `MPF_OFS_FRAME_ON:  nxt_st.frame_on = i_hwdata[3:0];
        `MPF_OFS_CHECKS:    nxt_st.checks = i_hwdata[19:0];
        `MPF_OFS_PRIO_GATE:
        begin
          nxt_st.rx_gate = i_hwdata[8:0];
          nxt_st.tx_gate = i_hwdata[`MPF_POS_TX_GATE +: 9];
        end
        `MPF_OFS_IRQ_STAT:  nxt_st.irq_stat = st_ff.irq_stat & ~i_hwdata[3:0];
        `MPF_OFS_IRQ_MASK:  nxt_st.irq_mask = i_hwdata[3:0];
        default:            nxt_st.irq_mask = st_ff.irq_mask;
      endcase
    end

    // acknowledge clears first, then a new frame sets, so the set wins
    nxt_st.req = (st_ff.req & ~i_rx_flow_frame_acknowledge) | slot_hit;
    nxt_st.valid = slot_hit;
    for (int i = 0; i <= PRIOS; i++)
    begin
      if (slot_hit[i])
      begin
        nxt_st.quanta[i] = slot_q[i];
      end
    end

    // transmit statistics only count frames that left with a good checksum
    if (i_tx_done.strobe && i_tx_done.fcs_good)
    begin
      nxt_st.stat_pause      = i_tx_done.global_pause;
      nxt_st.stat_user_pause = !i_tx_done.global_pause;
    end

    // sticky events, applied after the write-one-to-clear so a set is never lost
    if (frame_ok && (i_rx_frame.kind == MPF_GPP || i_rx_frame.kind == MPF_PPP))
    begin
      nxt_st.irq_stat[`MPF_IRQ_PAUSE_RX] = 1'b1;
    end
    if (frame_ok && (i_rx_frame.kind == MPF_GCP || i_rx_frame.kind == MPF_PCP))
    begin
      nxt_st.irq_stat[`MPF_IRQ_CTRL_RX] = 1'b1;
    end
    if (i_rx_frame.strobe && !frame_ok)
    begin
      nxt_st.irq_stat[`MPF_IRQ_REJECT] = 1'b1;
    end
    if (i_tx_done.strobe && i_tx_done.fcs_good)
    begin
      nxt_st.irq_stat[`MPF_IRQ_TX_PAUSE] = 1'b1;
    end

    // ahb address phase capture; only whole-word transfers are expected
    nxt_st.dp_pend  = addr_phase;
    // writes outside the register window must not alias onto offset zero
    nxt_st.dp_write = addr_phase & i_hwrite & (i_haddr[31:5] == '0);
    nxt_st.dp_addr  = addr_phase ? {i_haddr[4:2], 2'b00} : st_ff.dp_addr;
    if (addr_phase && !i_hwrite && i_haddr[31:5] == '0)
    begin
      nxt_st.rdata = read_word(nxt_st, {i_haddr[4:2], 2'b00});
    end
    else if (addr_phase)
    begin
      nxt_st.rdata = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_ff          <= '0;
      st_ff.frame_on <= `MPF_RST_FRAME_ON;
      st_ff.checks   <= `MPF_RST_CHECKS;
      st_ff.rx_gate  <= `MPF_RST_GATE;
      st_ff.tx_gate  <= `MPF_RST_GATE;
      st_ff.irq_mask <= `MPF_RST_MASK;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; the transmit gate is combinational so a dropped enable stops at once
  assign o_hreadyout          = 1'b1;
  assign o_hresp              = 1'b0;
  assign o_hrdata             = st_ff.rdata;
  assign o_rx_flow_request    = st_ff.req;
  assign o_rx_flow_valid      = st_ff.valid;
  assign o_rx_flow_quanta     = st_ff.quanta;
  assign o_tx_flow_frame_send = i_tx_flow_frame_request & st_ff.tx_gate;
  assign o_tx_stat_pause      = st_ff.stat_pause;
  assign o_tx_stat_user_pause = st_ff.stat_user_pause;
  assign o_irq                = |(st_ff.irq_stat & st_ff.irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // checks on the block's own behaviour
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_req_held_ack: assert property (
    o_rx_flow_request[8] && !i_rx_flow_frame_acknowledge[8] |=> o_rx_flow_request[8])
    else $error("request bit dropped without acknowledge");

  a_global_slot_hit: assert property (
    i_rx_frame.strobe && i_rx_frame.kind == MPF_GPP && frame_ok && st_ff.rx_gate[8]
    |=> o_rx_flow_valid == 9'h100 && o_rx_flow_request[8])
    else $error("global pause not reported on slot 8");

  a_quanta_match: assert property (
    o_rx_flow_valid[8] |-> o_rx_flow_quanta[8] == $past(i_rx_frame.quanta[0]))
    else $error("slot 8 quanta does not match received value");

  a_rx_gate_off: assert property (
    !st_ff.rx_gate[3] |=> !o_rx_flow_valid[3] && !$rose(o_rx_flow_request[3]))
    else $error("gated priority delivered to user");

  a_gpp_disabled: assert property (
    i_rx_frame.strobe && i_rx_frame.kind == MPF_GPP && !st_ff.frame_on[MPF_GPP]
    |=> o_rx_flow_valid == 9'h000)
    else $error("global pause handled while disabled");

  a_opcode_check: assert property (
    i_rx_frame.strobe && i_rx_frame.kind == MPF_PPP && !i_rx_frame.match[`MPF_CHK_OPCODE]
    && st_ff.checks[`MPF_CHK_WIDTH*3 + `MPF_CHK_OPCODE] |=> o_rx_flow_valid == 9'h000)
    else $error("priority pause accepted with failed opcode check");

  a_opcode_ignored: assert property (
    i_rx_frame.strobe && i_rx_frame.kind == MPF_PPP && st_ff.frame_on[MPF_PPP]
    && i_rx_frame.match == 5'h0f && !st_ff.checks[`MPF_CHK_WIDTH*3 + `MPF_CHK_OPCODE]
    && st_ff.checks[`MPF_CHK_WIDTH*3 +: 4] != 4'h0 && i_rx_frame.prio_vec[0] && st_ff.rx_gate[0]
    |=> o_rx_flow_valid[0])
    else $error("disabled opcode check still rejected frame");

  a_gcp_disabled: assert property (
    i_rx_frame.strobe && i_rx_frame.kind == MPF_GCP && !st_ff.frame_on[MPF_GCP]
    |=> st_ff.irq_stat[`MPF_IRQ_REJECT])
    else $error("global control frame taken while disabled");

  a_tx_gate_send: assert property (
    i_tx_flow_frame_request[5] |-> o_tx_flow_frame_send[5] == st_ff.tx_gate[5])
    else $error("transmit gate not applied");

  a_tx_stat_pulse: assert property (
    i_tx_done.strobe && i_tx_done.fcs_good && i_tx_done.global_pause
    |=> o_tx_stat_pause && !o_tx_stat_user_pause
        ##1 (!o_tx_stat_pause || $past(i_tx_done.strobe && i_tx_done.fcs_good && i_tx_done.global_pause)))
    else $error("global pause statistic pulse wrong");

  // statistics pulses track good transmitted pause frames one for one
  a_user_stat_pulse: assert property (
    i_tx_done.strobe && i_tx_done.fcs_good && !i_tx_done.global_pause
    |=> o_tx_stat_user_pause && !o_tx_stat_pause)
    else $error("priority pause statistic pulse wrong");

  a_stat_idle: assert property (
    !(i_tx_done.strobe && i_tx_done.fcs_good) |=> !o_tx_stat_pause && !o_tx_stat_user_pause)
    else $error("statistic pulse without a good transmitted pause frame");

  a_pcp_disabled: assert property (
    i_rx_frame.strobe && i_rx_frame.kind == MPF_PCP && !st_ff.frame_on[MPF_PCP]
    |=> st_ff.irq_stat[`MPF_IRQ_REJECT] && !$rose(st_ff.irq_stat[`MPF_IRQ_CTRL_RX]))
    else $error("priority control frame taken while disabled");

  a_ppp_disabled: assert property (
    i_rx_frame.strobe && i_rx_frame.kind == MPF_PPP && !st_ff.frame_on[MPF_PPP]
    |=> o_rx_flow_valid == 9'h000 && st_ff.irq_stat[`MPF_IRQ_REJECT])
    else $error("priority pause handled while disabled");

  // any enabled check that fails must reject the frame
  a_gcp_check: assert property (
    i_rx_frame.strobe && i_rx_frame.kind == MPF_GCP
    && (|(st_ff.checks[0 +: `MPF_CHK_WIDTH] & ~i_rx_frame.match))
    |=> st_ff.irq_stat[`MPF_IRQ_REJECT])
    else $error("global control frame passed a failed enabled check");

  a_pcp_check: assert property (
    i_rx_frame.strobe && i_rx_frame.kind == MPF_PCP
    && (|(st_ff.checks[`MPF_CHK_WIDTH +: `MPF_CHK_WIDTH] & ~i_rx_frame.match))
    |=> st_ff.irq_stat[`MPF_IRQ_REJECT])
    else $error("priority control frame passed a failed enabled check");

  a_gpp_check: assert property (
    i_rx_frame.strobe && i_rx_frame.kind == MPF_GPP
    && (|(st_ff.checks[`MPF_CHK_WIDTH*2 +: `MPF_CHK_WIDTH] & ~i_rx_frame.match))
    |=> o_rx_flow_valid == 9'h000 && st_ff.irq_stat[`MPF_IRQ_REJECT])
    else $error("global pause passed a failed enabled check");

  a_ppp_mcast_check: assert property (
    i_rx_frame.strobe && i_rx_frame.kind == MPF_PPP && !i_rx_frame.match[`MPF_CHK_MCAST]
    && st_ff.checks[`MPF_CHK_WIDTH*3 + `MPF_CHK_MCAST]
    |=> o_rx_flow_valid == 9'h000)
    else $error("priority pause accepted with failed multicast check");

  a_req_set: assert property (
    slot_hit != 9'h000 |=> (o_rx_flow_request & $past(slot_hit)) == $past(slot_hit))
    else $error("accepted pause frame did not raise its request");

  a_ack_clears: assert property (
    o_rx_flow_request[8] && i_rx_flow_frame_acknowledge[8] && !slot_hit[8] |=> !o_rx_flow_request[8])
    else $error("acknowledged request bit not cleared");

  a_valid_has_req: assert property (
    (o_rx_flow_valid & ~o_rx_flow_request) == 9'h000)
    else $error("quanta valid without a pending request");

  a_quanta_prio: assert property (
    o_rx_flow_valid[5] |-> o_rx_flow_quanta[5] == $past(i_rx_frame.quanta[5]))
    else $error("priority 5 quanta does not match received value");
endmodule
`default_nettype wire

// *** verification/mpf_user_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mpf_user_model (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_hold,
  input  wire logic [8:0]       i_request,
  input  wire logic [8:0]       i_valid,
  input  wire logic [8:0][15:0] i_quanta,
  output logic      [8:0]       o_ack,
  output logic      [8:0][15:0] o_taken
);
  // acks a cycle late; hold plays a busy user that keeps requests waiting
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_ack   <= 9'h000;
      o_taken <= '0;
    end
    else
    begin
      o_ack <= i_request & ~{9{i_hold}};
      for (int i = 0; i < 9; i++)
        if (i_valid[i]) o_taken[i] <= i_quanta[i];
    end
  end
endmodule
`default_nettype wire

// *** verification/mpf_pause_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mpf_regs.svh"
module mpf_pause_ctrl_tb;
  import mpf_pkg::*;
  logic             i_clk = 1'b0;
  logic             i_rst_n = 1'b0;
  logic             hsel = 1'b0;
  logic             hwrite = 1'b0;
  logic             hold = 1'b0;
  logic [1:0]       htrans = 2'b00;
  logic [31:0]      haddr = 32'h0;
  logic [31:0]      hwdata = 32'h0;
  logic [31:0]      hrdata, v;
  logic             hrdy, hresp, st_p, st_u, irq;
  logic [8:0]       ack, req, vld, send;
  logic [8:0]       txr = 9'h000;
  logic [8:0][15:0] q, taken;
  mpf_rx_frame_t    rxf = '0;
  mpf_tx_done_t     txd = '0;
  int               n_fail = 0;
  int               total_checks = 0;
  int               exp;

  // 250 MHz clock
  always #2 i_clk = ~i_clk;

  mpf_pause_ctrl i_mpf_pause_ctrl (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata), .i_rx_frame(rxf),
    .i_rx_flow_frame_acknowledge(ack), .o_rx_flow_request(req), .o_rx_flow_valid(vld),
    .o_rx_flow_quanta(q), .i_tx_flow_frame_request(txr), .o_tx_flow_frame_send(send),
    .i_tx_done(txd), .o_tx_stat_pause(st_p), .o_tx_stat_user_pause(st_u), .o_irq(irq));
  mpf_user_model i_mpf_user_model (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hold(hold), .i_request(req),
    .i_valid(vld), .i_quanta(q), .o_ack(ack), .o_taken(taken));
  ////////////////////////////////////////////////////////////////////////////////
  // compare and count; unknowns never match thanks to case equality
  task chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask
  // one ahb-lite single word transfer; no wait count assumed, the watchdog bounds it
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge i_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge i_clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge i_clk); while (hrdy !== 1'b1);
    v = hrdata;
  endtask
  task wr(input logic [4:0] o, input logic [31:0] d);
    ahb(1'b1, {27'h0, o}, d);
  endtask
  task rdc(input logic [4:0] o, input logic [31:0] want, input string what);
    ahb(1'b0, {27'h0, o}, 32'h0);
    chk(what, v, want);
  endtask
  // frame strobes last one cycle; return once the answer cycle has settled
  task rx(input mpf_class_t k, input logic [4:0] m, input logic [7:0] pv, input logic [15:0] qb);
    @(posedge i_clk);
    rxf.strobe <= 1'b1;
    rxf.kind <= k;
    rxf.match <= m;
    rxf.prio_vec <= pv;
    for (int i = 0; i < 8; i++)
      rxf.quanta[i] <= qb + 16'(i);
    @(posedge i_clk);
    rxf.strobe <= 1'b0;
    #1;
  endtask
  task tx(input logic g, input logic f);
    @(posedge i_clk);
    txd <= '{1'b1, g, f};
    @(posedge i_clk);
    txd.strobe <= 1'b0;
    #1;
  endtask
  task report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog, well above the roughly 1300 cycles the tests need
  initial
  begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    report_and_stop();
  end
  initial
  begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rdc(`MPF_OFS_FRAME_ON, 32'hf, "frame_on");
    rdc(`MPF_OFS_CHECKS, 32'hfffff, "checks");
    rdc(`MPF_OFS_PRIO_GATE, 32'h01ff01ff, "gates");
    rdc(`MPF_OFS_IRQ_MASK, 32'h0, "irq_mask");
    ahb(1'b1, 32'h20, 32'h0);
    ahb(1'b0, 32'h20, 32'h0);
    chk("unmapped", v, 32'h0);
    rdc(`MPF_OFS_FRAME_ON, 32'hf, "no alias");
    chk("ready resp", 32'({hrdy, hresp}), 32'h2);
    $display("test reset done");
    // global pause held by a busy user; request must outlive the stall
    @(posedge i_clk);
    hold <= 1'b1;
    rx(MPF_GPP, 5'h1f, 8'h00, 16'h1234);
    chk("valid", 32'(vld), 32'h100);
    chk("quanta8", 32'(q[8]), 32'h1234);
    repeat (5) @(posedge i_clk);
    #1 chk("req held", 32'(req), 32'h100);
    rdc(`MPF_OFS_STATUS, 32'h100, "status");
    @(posedge i_clk);
    hold <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1 chk("req cleared", 32'(req), 32'h0);
    chk("taken8", 32'(taken[8]), 32'h1234);
    $display("test gpp done");
    // priority pause through a partial receive gate
    wr(`MPF_OFS_PRIO_GATE, 32'h01ff00f0);
    rx(MPF_PPP, 5'h1f, 8'ha5, 16'h0100);
    chk("valid ppp", 32'(vld), 32'h0a0);
    chk("quanta5", 32'(q[5]), 32'h0105);
    chk("quanta7", 32'(q[7]), 32'h0107);
    chk("quanta0", 32'(q[0]), 32'h0);
    wr(`MPF_OFS_PRIO_GATE, 32'h01ff01ff);
    $display("test ppp done");
    // every class: class enable, then each single check against each failing field
    for (int k = 0; k < 4; k++)
    begin
      wr(`MPF_OFS_IRQ_STAT, 32'hf);
      wr(`MPF_OFS_FRAME_ON, 32'hf & ~(32'h1 << k));
      rx(mpf_class_t'(k), 5'h1f, 8'h01, 16'h0);
      rdc(`MPF_OFS_IRQ_STAT, 32'h2, "class off");
      wr(`MPF_OFS_FRAME_ON, 32'hf);
      for (int c = 0; c < 5; c++)
        for (int m = 0; m < 5; m++)
        begin
          wr(`MPF_OFS_IRQ_STAT, 32'hf);
          wr(`MPF_OFS_CHECKS, 32'h1 << (5 * k + c));
          rx(mpf_class_t'(k), ~(5'h1 << m), 8'h01, 16'h0);
          exp = (m == c) ? 2 : ((k >= 2) ? 1 : 4);
          rdc(`MPF_OFS_IRQ_STAT, 32'(exp), "check");
        end
    end
    wr(`MPF_OFS_CHECKS, 32'hfffff);
    $display("test checks done");
    // transmit statistics and the masked interrupt
    wr(`MPF_OFS_IRQ_STAT, 32'hf);
    wr(`MPF_OFS_IRQ_MASK, 32'h8);
    tx(1'b1, 1'b1);
    chk("stat pause", 32'({st_p, st_u}), 32'h2);
    tx(1'b0, 1'b1);
    chk("stat user", 32'({st_p, st_u}), 32'h1);
    tx(1'b1, 1'b0);
    chk("bad fcs", 32'({st_p, st_u}), 32'h0);
    chk("irq on", 32'(irq), 32'h1);
    wr(`MPF_OFS_IRQ_MASK, 32'h0);
    #1 chk("irq masked", 32'(irq), 32'h0);
    wr(`MPF_OFS_IRQ_STAT, 32'h8);
    rdc(`MPF_OFS_IRQ_STAT, 32'h0, "irq clear");
    $display("test tx done");
    // transmit gate; user holds the request beyond sixteen cycles
    wr(`MPF_OFS_PRIO_GATE, 32'h00aa01ff);
    @(posedge i_clk);
    txr <= 9'h1ff;
    repeat (16) @(posedge i_clk);
    #1 chk("tx send", 32'(send), 32'h0aa);
    $display("test gate done");
    report_and_stop();
  end
endmodule
`default_nettype wire
